// ### rtl/flash_cmd_regs.svh
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// instruction codes
`define OP_READ 8'h03
`define OP_READ4 8'h13
`define OP_FAST 8'h0B
`define OP_FAST4 8'h0C
`define OP_DUAL_RD 8'h3B
`define OP_DUAL_RD4 8'h3C
`define OP_QIOR 8'hEB
`define OP_QIOR4 8'hEC
`define OP_BOOT_RD 8'h14
`define OP_BOOT_WR 8'h15
`define OP_WR_ENABLE 8'h06
`define OP_WRDI 8'h04
`define OP_CLSR 8'h30

// status_register_1 bit positions
`define STAT_BUSY_BIT 0
`define STAT_WR_ENABLE_BIT 1
`define STAT_ERASE_ERR_BIT 5
`define STAT_PROG_ERR_BIT 6

// reset and erased values
`define BOOT_REG_RST 32'h00000000
`define BOOT_REG_ERASED 32'hFFFFFFFF

// framing counts
`define OPCODE_LAST 6'h07
`define ADDR3_LAST 6'h17
`define ADDR4_LAST 6'h1F
`define BOOT_BITS 6'h20
`define BOOT_OVER 6'h21
`define DUMMY_COUNT 4'h8
`define LATENCY_NO_DUMMY 2'h3

// timing
`define MCLK_PERIOD_PS 5000
`define ERASE_TIME_US 200
`define PROG_TIME_US 100

`define DATA_FIFO_DEPTH 16
`define DATA_FIFO_WIDTH 8

`endif

// ### rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_BREAD,
		ST_BWRITE,
		ST_TAIL,
		ST_IGNORE
	} cmd_state_e;

	typedef enum logic [1:0] {
		U_IDLE,
		U_ERASE,
		U_PROG
	} upd_state_e;

endpackage : flash_cmd_pkg

// ### rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready_o = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem_r[rd_ptr_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : word_fifo

// ### rtl/spi_flash_read_and_bootreg_cmds.sv
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"
module spi_flash_read_and_bootreg_cmds
	import flash_cmd_pkg::*;
#(
	parameter int ERASE_CYCLES = (`ERASE_TIME_US * 1000 * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS,
	parameter int PROG_CYCLES = (`PROG_TIME_US * 1000 * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_io0_i,
	output logic si_io0_o,
	output logic si_io0_oe_o,
	input wire logic so_io1_i,
	output logic so_io1_o,
	output logic so_io1_oe_o,
	input wire logic [1:0] latency_code_i,
	input wire logic extended_address_bit_i,
	input wire logic erase_fail_i,
	input wire logic program_fail_i,
	output logic mem_rd_o,
	output logic [23:0] mem_addr_o,
	input wire logic [7:0] mem_rdata_i,
	output logic [7:0] status_register_1_o,
	output logic [31:0] boot_reg_o
);

	function automatic logic takes_4byte(input logic [7:0] op, input logic ext);
		takes_4byte = (op == `OP_READ4) || (op == `OP_FAST4) || (op == `OP_DUAL_RD4) || ext;
	endfunction : takes_4byte

	function automatic logic takes_dummy(input logic [7:0] op, input logic [1:0] lc);
		takes_dummy = (op != `OP_READ) && (op != `OP_READ4) && (lc != `LATENCY_NO_DUMMY);
	endfunction : takes_dummy

	// pin synchronisers; stage [0] is read only by stage [1]
	logic [1:0] sck_sync_r;
	logic [1:0] cs_sync_r;
	logic [1:0] io0_sync_r;
	logic [1:0] io1_sync_r;
	logic sck_q_r;
	logic cs_q_r;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_active;
	logic si_bit;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sck_sync_r <= 2'h0;
			cs_sync_r <= 2'h3;
			io0_sync_r <= 2'h0;
			io1_sync_r <= 2'h0;
			sck_q_r <= 1'b0;
			cs_q_r <= 1'b1;
		end else begin
			sck_sync_r <= {sck_sync_r[0], sck_i};
			cs_sync_r <= {cs_sync_r[0], cs_n_i};
			io0_sync_r <= {io0_sync_r[0], si_io0_i};
			io1_sync_r <= {io1_sync_r[0], so_io1_i};
			sck_q_r <= sck_sync_r[1];
			cs_q_r <= cs_sync_r[1];
		end
	end

	// io1 input is unused by these single-input commands; kept synchronised for a dual-input path
	assign sck_rise = sck_sync_r[1] & ~sck_q_r;
	assign sck_fall = ~sck_sync_r[1] & sck_q_r;
	assign cs_rise = cs_sync_r[1] & ~cs_q_r;
	assign cs_active = ~cs_sync_r[1];
	assign si_bit = io0_sync_r[1];

	cmd_state_e state_r;
	logic [5:0] cnt_r;
	logic [7:0] op_r;
	logic [7:0] op_nxt;
	logic [31:0] addr_r;
	logic [31:0] addr_nxt;
	logic [5:0] addr_last_r;
	logic dummy_r;
	logic dual_r;
	logic [3:0] dcnt_r;
	logic [31:0] wdata_r;
	logic addr_done;
	logic drive_data;

	logic write_enable_latch_r;
	logic eerr_r;
	logic perr_r;
	upd_state_e upd_r;
	logic [31:0] timer_r;
	logic [31:0] upd_data_r;
	logic [31:0] boot_reg_r;
	logic upd_done;
	logic upd_erase_bad;
	logic upd_prog_bad;
	logic busy;

	logic write_enable_go;
	logic wrdi_go;
	logic clsr_go;
	logic bw_go;

	assign op_nxt = {op_r[6:0], si_bit};
	assign addr_nxt = {addr_r[30:0], si_bit};
	assign addr_done = (state_r == ST_ADDR) && sck_rise && (cnt_r == addr_last_r);
	assign busy = (upd_r != U_IDLE);

	// simple commands act only if select rises right after the 8th bit
	assign write_enable_go = cs_rise && (state_r == ST_TAIL) && (op_r == `OP_WR_ENABLE) && (cnt_r == '0) && !busy;
	assign wrdi_go = cs_rise && (state_r == ST_TAIL) && (op_r == `OP_WRDI) && (cnt_r == '0) && !busy;
	assign clsr_go = cs_rise && (state_r == ST_TAIL) && (op_r == `OP_CLSR) && (cnt_r == '0);
	assign bw_go = cs_rise && (state_r == ST_BWRITE) && (cnt_r == `BOOT_BITS) &&
		write_enable_latch_r && !busy;

	// command framing
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			op_r <= '0;
			addr_r <= '0;
			addr_last_r <= `ADDR3_LAST;
			dummy_r <= 1'b0;
			dual_r <= 1'b0;
			dcnt_r <= '0;
			wdata_r <= '0;
		end else if (!cs_active) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (sck_rise) begin
						op_r <= op_nxt;
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == `OPCODE_LAST) begin
							cnt_r <= '0;
							dual_r <= (op_nxt == `OP_DUAL_RD) || (op_nxt == `OP_DUAL_RD4);
							dummy_r <= takes_dummy(op_nxt, latency_code_i);
							addr_last_r <= takes_4byte(op_nxt, extended_address_bit_i) ? `ADDR4_LAST : `ADDR3_LAST;
							case (op_nxt)
								`OP_READ, `OP_READ4, `OP_FAST, `OP_FAST4, `OP_DUAL_RD, `OP_DUAL_RD4: state_r <= ST_ADDR;
								`OP_BOOT_RD: state_r <= ST_BREAD;
								`OP_BOOT_WR: state_r <= ST_BWRITE;
								`OP_WR_ENABLE, `OP_WRDI, `OP_CLSR: state_r <= ST_TAIL;
								// quad I/O and its mode bits need IO2/IO3, absent here
								default: state_r <= ST_IGNORE;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (sck_rise) begin
						addr_r <= addr_nxt;
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == addr_last_r) begin
							dcnt_r <= '0;
							state_r <= dummy_r ? ST_DUMMY : ST_DATA;
						end
					end
				end
				ST_DUMMY: begin
					// inputs are not looked at here
					if (sck_fall) begin
						if (dcnt_r == `DUMMY_COUNT) begin
							state_r <= ST_DATA;
						end else begin
							dcnt_r <= dcnt_r + 1'b1;
						end
					end
				end
				ST_BWRITE: begin
					if (sck_rise) begin
						if (cnt_r < `BOOT_BITS) begin
							wdata_r[{cnt_r[4:3], ~cnt_r[2:0]}] <= si_bit;
						end
						if (cnt_r != `BOOT_OVER) begin
							cnt_r <= cnt_r + 1'b1;
						end
					end
				end
				ST_TAIL: begin
					if (sck_rise) begin
						cnt_r <= 6'h01;
					end
				end
				ST_DATA, ST_BREAD, ST_IGNORE: begin
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// self-timed boot register update: erase then program
	assign upd_erase_bad = (upd_r == U_ERASE) && (timer_r == 32'(ERASE_CYCLES - 1)) && erase_fail_i;
	assign upd_prog_bad = (upd_r == U_PROG) && (timer_r == 32'(PROG_CYCLES - 1)) && program_fail_i;
	assign upd_done = upd_erase_bad || ((upd_r == U_PROG) && (timer_r == 32'(PROG_CYCLES - 1)));

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			upd_r <= U_IDLE;
			timer_r <= '0;
			upd_data_r <= '0;
			boot_reg_r <= `BOOT_REG_RST;
		end else begin
			case (upd_r)
				U_IDLE: begin
					timer_r <= '0;
					if (bw_go) begin
						upd_data_r <= wdata_r;
						upd_r <= U_ERASE;
					end
				end
				U_ERASE: begin
					timer_r <= timer_r + 1'b1;
					if (timer_r == 32'(ERASE_CYCLES - 1)) begin
						timer_r <= '0;
						if (erase_fail_i) begin
							upd_r <= U_IDLE;
						end else begin
							boot_reg_r <= `BOOT_REG_ERASED;
							upd_r <= U_PROG;
						end
					end
				end
				U_PROG: begin
					timer_r <= timer_r + 1'b1;
					if (timer_r == 32'(PROG_CYCLES - 1)) begin
						if (!program_fail_i) begin
							boot_reg_r <= upd_data_r;
						end
						upd_r <= U_IDLE;
					end
				end
				default: upd_r <= U_IDLE;
			endcase
		end
	end

	// status flags; a failure in the clear cycle still lands
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			write_enable_latch_r <= 1'b0;
			eerr_r <= 1'b0;
			perr_r <= 1'b0;
		end else begin
			if (wrdi_go || upd_done) begin
				write_enable_latch_r <= 1'b0;
			end
			if (write_enable_go) begin
				write_enable_latch_r <= 1'b1;
			end
			if (clsr_go) begin
				eerr_r <= 1'b0;
				perr_r <= 1'b0;
			end
			if (upd_erase_bad) begin
				eerr_r <= 1'b1;
			end
			if (upd_prog_bad) begin
				perr_r <= 1'b1;
			end
		end
	end

	always_comb begin
		status_register_1_o = 8'h00;
		status_register_1_o[`STAT_BUSY_BIT] = busy;
		status_register_1_o[`STAT_WR_ENABLE_BIT] = write_enable_latch_r;
		status_register_1_o[`STAT_ERASE_ERR_BIT] = eerr_r;
		status_register_1_o[`STAT_PROG_ERR_BIT] = perr_r;
	end
	assign boot_reg_o = boot_reg_r;

	// array prefetch into the byte fifo, one read in flight
	logic [23:0] pf_addr_r;
	logic pf_active_r;
	logic pend_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	logic issue;

	assign issue = pf_active_r && cs_active && !pend_r && fifo_in_ready;
	assign mem_rd_o = issue;
	assign mem_addr_o = pf_addr_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pf_addr_r <= '0;
			pf_active_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			pend_r <= issue;
			if (!cs_active) begin
				pf_active_r <= 1'b0;
			end else if (addr_done) begin
				pf_addr_r <= addr_nxt[23:0];
				pf_active_r <= 1'b1;
			end else if (issue) begin
				pf_addr_r <= pf_addr_r + 1'b1;
			end
		end
	end

	// flushed at every select rise so a stale byte never leads the next read
	word_fifo #(
		.WIDTH(`DATA_FIFO_WIDTH),
		.DEPTH(`DATA_FIFO_DEPTH)
	) u_data_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.flush_i(!cs_active),
		.in_valid_i(pend_r && pf_active_r && cs_active),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_rdata_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	// output shifter, data changes on sck falls; the output enables drop on deselect or in ST_IDLE
	logic [7:0] shift_r;
	logic [3:0] left_r;
	logic [4:0] bcnt_r;
	logic [7:0] load_byte;

	assign drive_data = sck_fall && cs_active &&
		((state_r == ST_DATA) || ((state_r == ST_DUMMY) && (dcnt_r == `DUMMY_COUNT)));
	assign fifo_pop = drive_data && (left_r == '0) && fifo_out_valid;
	// underrun limitation: an empty fifo returns all ones
	assign load_byte = fifo_out_valid ? fifo_out_data : 8'hFF;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			so_io1_o <= 1'b0;
			so_io1_oe_o <= 1'b0;
			si_io0_o <= 1'b0;
			si_io0_oe_o <= 1'b0;
			shift_r <= '0;
			left_r <= '0;
			bcnt_r <= '0;
		end else if (!cs_active || (state_r == ST_IDLE)) begin
			so_io1_oe_o <= 1'b0;
			si_io0_oe_o <= 1'b0;
			left_r <= '0;
			bcnt_r <= '0;
		end else if (state_r == ST_BREAD && sck_fall) begin
			so_io1_o <= boot_reg_r[{bcnt_r[4:3], ~bcnt_r[2:0]}];
			so_io1_oe_o <= 1'b1;
			bcnt_r <= bcnt_r + 1'b1;
		end else if (drive_data) begin
			so_io1_oe_o <= 1'b1;
			si_io0_oe_o <= dual_r;
			if (left_r == '0) begin
				so_io1_o <= load_byte[7];
				if (dual_r) begin
					si_io0_o <= load_byte[6];
					shift_r <= {load_byte[5:0], 2'h0};
					left_r <= 4'h6;
				end else begin
					shift_r <= {load_byte[6:0], 1'b0};
					left_r <= 4'h7;
				end
			end else begin
				so_io1_o <= shift_r[7];
				if (dual_r) begin
					si_io0_o <= shift_r[6];
					shift_r <= {shift_r[5:0], 2'h0};
					left_r <= left_r - 4'h2;
				end else begin
					shift_r <= {shift_r[6:0], 1'b0};
					left_r <= left_r - 4'h1;
				end
			end
		end
	end

endmodule : spi_flash_read_and_bootreg_cmds

// ### dv/flash_cmd_monitor.sv
`timescale 1ns/1ps
module flash_cmd_monitor #(
	parameter int ERASE_CYCLES = 20,
	parameter int PROG_CYCLES = 10
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic so_io1_o,
	input wire logic so_io1_oe_o,
	input wire logic si_io0_oe_o,
	input wire logic mem_rd_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic [7:0] status_register_1_o,
	input wire logic [31:0] boot_reg_o
);
	logic [23:0] last_r;
	logic seen_r;
	int busy_r;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// a select frame restarts the address chain
	always_ff @(posedge mclk_i) begin
		if (rst_i || cs_n_i) seen_r <= 1'b0;
		else if (mem_rd_o) seen_r <= 1'b1;
	end
	always_ff @(posedge mclk_i) begin
		if (mem_rd_o) last_r <= mem_addr_o;
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i || !status_register_1_o[0]) busy_r <= 0;
		else busy_r <= busy_r + 1;
	end
	a_spare_bits_zero: assert property (status_register_1_o[4:2] == 3'h0 && !status_register_1_o[7])
		else $error("status spare bits set");
	a_addr_steps: assert property (mem_rd_o && seen_r |-> mem_addr_o == last_r + 24'h1)
		else $error("array address did not step by one");
	a_oe_off_idle: assert property (cs_n_i [*8] |-> !so_io1_oe_o && !si_io0_oe_o)
		else $error("output enabled while deselected");
	a_out_on_fall: assert property (!cs_n_i && $changed(so_io1_o) |-> !sck_i && !$past(sck_i, 2))
		else $error("output changed away from a falling edge");
	a_wip_after_cs: assert property ($rose(status_register_1_o[0]) |-> cs_n_i && $past(cs_n_i))
		else $error("update started while selected");
	a_wip_needs_wel: assert property ($rose(status_register_1_o[0]) |-> $past(status_register_1_o[1]))
		else $error("update started without write enable");
	a_wel_clears_end: assert property ($fell(status_register_1_o[0]) |-> !status_register_1_o[1])
		else $error("write enable left set after update");
	a_boot_only_update: assert property ($changed(boot_reg_o) |-> status_register_1_o[0] ||
		$past(status_register_1_o[0]))
		else $error("boot register changed outside update");
	a_wip_bounded: assert property (busy_r <= ERASE_CYCLES + PROG_CYCLES)
		else $error("update ran too long");
	a_err_in_update: assert property ($rose(status_register_1_o[5]) || $rose(status_register_1_o[6]) |->
		$past(status_register_1_o[0]))
		else $error("error flag set outside update");
endmodule : flash_cmd_monitor

// ### dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	input wire logic mclk_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	output logic si_oe_o,
	input wire logic io0_i,
	input wire logic io1_i
);
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		si_oe_o = 1'b0;
	end
	// half of a 160 ns link period
	task automatic half();
		repeat (16) @(posedge mclk_i);
	endtask : half
	// tx is aligned to bit 39, sent first
	task automatic frame(input logic [39:0] tx, input int ntx, input int ndum, input int nrx, input bit dual,
		output logic [63:0] rx);
		rx = '0;
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		// data moves with the fall, so one bit spans 32 clocks
		for (int i = 0; i < ntx + ndum + nrx; i++) begin
			if (i < ntx) begin
				si_oe_o <= 1'b1;
				si_o <= tx[39-i];
			end else begin
				si_oe_o <= 1'b0;
				si_o <= ~si_o;
			end
			half();
			sck_o <= 1'b1;
			if (i >= ntx + ndum) rx = dual ? {rx[61:0], io1_i, io0_i} : {rx[62:0], io1_i};
			half();
			sck_o <= 1'b0;
		end
		half();
		cs_n_o <= 1'b1;
		repeat (8) @(posedge mclk_i);
	endtask : frame
endmodule : spi_host_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import flash_cmd_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, cs_n, sck, h_si, h_oe, io0, io1, si_o, si_oe, so_o, so_oe;
	logic [1:0] lc = 2'h0;
	logic ext = 1'b0, efail = 1'b0, pfail = 1'b0, mem_rd;
	logic [23:0] mem_addr;
	logic [7:0] mem_rdata = 8'h00, status;
	logic [31:0] boot;
	int fails = 0, compares = 0;
	assign io0 = si_oe ? si_o : h_si;
	assign io1 = so_oe ? so_o : sck;
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	spi_host_model u_host (.mclk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .si_o(h_si), .si_oe_o(h_oe),
		.io0_i(io0), .io1_i(io1));
	spi_flash_read_and_bootreg_cmds #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) DUT (.mclk_i(mclk), .rst_i(rst),
		.cs_n_i(cs_n), .sck_i(sck), .si_io0_i(io0), .si_io0_o(si_o), .si_io0_oe_o(si_oe), .so_io1_i(io1),
		.so_io1_o(so_o), .so_io1_oe_o(so_oe), .latency_code_i(lc), .extended_address_bit_i(ext),
		.erase_fail_i(efail), .program_fail_i(pfail), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
		.mem_rdata_i(mem_rdata), .status_register_1_o(status), .boot_reg_o(boot));
	function automatic logic [7:0] byte_at(input logic [23:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h5A;
	endfunction : byte_at
	function automatic logic [31:0] swap(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : swap
	// array answers one cycle after each request
	always @(posedge mclk) begin
		if (mem_rd === 1'b1) mem_rdata <= byte_at(mem_addr);
		if (si_oe === 1'b1 && h_oe === 1'b1) begin
			fails++;
			$display("Error io0 driven by both sides");
		end
	end
	task automatic wrap_up();
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_bit(input int idx, input logic val, input int lim, input bit must, output bit hit);
		hit = 1'b0;
		for (int n = 0; n < lim && !hit; n++) begin
			@(posedge mclk);
			#1;
			hit = (status[idx] === val);
		end
		if (must && !hit) begin
			fails++;
			wrap_up();
		end
	endtask : wait_bit
	task automatic s_boot_write(input logic [31:0] v, input int nbits, input bit write_enable_cmd, input bit acc,
		input logic [7:0] st, input logic [31:0] bv);
		logic [63:0] rx;
		bit hit;
		if (write_enable_cmd) u_host.frame({8'h06, 32'h0}, 8, 0, 0, 0, rx);
		u_host.frame({8'h15, swap(v)}, 8 + nbits, 0, 0, 0, rx);
		wait_bit(0, 1'b1, 12, 1'b0, hit);
		check("update_started", hit, acc);
		if (hit) wait_bit(0, 1'b0, 100, 1'b1, hit);
		check("status", status, st);
		check("boot_reg", boot, bv);
	endtask : s_boot_write
	task automatic s_clear();
		logic [63:0] rx;
		u_host.frame({8'h30, 32'h0}, 8, 0, 0, 0, rx);
		check("status_cleared", status, 8'h00);
	endtask : s_clear
	task automatic s_boot_read(input logic [31:0] v);
		logic [63:0] rx;
		u_host.frame({8'h14, 32'h0}, 8, 0, 64, 0, rx);
		check("boot_read", rx, {swap(v), swap(v)});
	endtask : s_boot_read
	task automatic s_read(input logic [7:0] op, input logic [31:0] a, input bit a4, input bit dual,
		input int nb, input int ndum);
		logic [63:0] rx, exp;
		exp = '0;
		for (int k = 0; k < nb; k++) exp = {exp[55:0], byte_at(a[23:0] + 24'(k))};
		u_host.frame(a4 ? {op, a} : {op, a[23:0], 8'h00}, a4 ? 40 : 32, ndum, nb * (dual ? 4 : 8), dual, rx);
		check("read_data", rx, exp);
	endtask : s_read
	initial begin
		logic [63:0] rx;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		s_boot_read(32'h0);
		s_boot_write(32'hA5C30F81, 32, 0, 0, 8'h00, 32'h0);
		s_boot_write(32'hA5C30F81, 31, 1, 0, 8'h02, 32'h0);
		s_boot_write(32'h12345678, 32, 1, 1, 8'h00, 32'h12345678);
		s_boot_read(32'h12345678);
		efail <= 1'b1;
		s_boot_write(32'h0, 32, 1, 1, 8'h20, 32'h12345678);
		efail <= 1'b0;
		s_clear();
		pfail <= 1'b1;
		s_boot_write(32'h0, 32, 1, 1, 8'h40, 32'hFFFFFFFF);
		pfail <= 1'b0;
		s_clear();
		s_read(8'h03, 32'h000010, 0, 0, 4, 0);
		s_read(8'h0B, 32'h000100, 0, 0, 4, 8);
		s_read(8'h3B, 32'hFFFFFE, 0, 1, 4, 8);
		s_read(8'h13, 32'hAB000020, 1, 0, 4, 0);
		s_read(8'h0C, 32'hFF7F0030, 1, 0, 4, 8);
		s_read(8'h3C, 32'h01FFFFFC, 1, 1, 8, 8);
		u_host.frame({8'h03, 24'h000040, 8'h00}, 32, 0, 12, 0, rx);
		check("cut_read", rx[11:0], {byte_at(24'h40), byte_at(24'h41)} >> 4);
		ext <= 1'b1;
		s_read(8'h03, 32'h5A000050, 1, 0, 4, 0);
		s_read(8'h0B, 32'h00123456, 1, 0, 4, 8);
		s_read(8'h3B, 32'h80000060, 1, 1, 4, 8);
		lc <= 2'h3;
		s_read(8'h0B, 32'h00000070, 1, 0, 4, 0);
		s_read(8'h3C, 32'h00000080, 1, 1, 4, 0);
		wrap_up();
	end
endmodule : tb_top
bind spi_flash_read_and_bootreg_cmds flash_cmd_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES))
	u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .so_io1_o(so_io1_o),
	.so_io1_oe_o(so_io1_oe_o), .si_io0_oe_o(si_io0_oe_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
	.status_register_1_o(status_register_1_o), .boot_reg_o(boot_reg_o));
